// ===== hw/icw_ctrl.sv
// interrupt priority, vector selection and wait/halt wake controller
// Behaviour
// - servicing entry sets the global mask
// - simultaneous requests served by fixed vector priority
// - trap always vectors, never wakes halt
// - every external and peripheral interrupt source ends wait, trap does not
// - only reset and external groups end halt
// - external vector needs event and clear mask
// - edge requests latched, cleared on service entry
// - enabled pins of group ANDed before detector
// - low shared pin blocks even rising edge
// - peripheral flag needs clear mask and enable
// - blocked peripheral flag stays pending latched
// - clear sequence also drops pending latch
// - four external groups, own descending vectors
// - sync serial, timer a, timer b vectors
// - async serial shared, nvm lowest vector
// - wait stops cpu, peripherals keep running
// - entering wait clears the global mask
// - wait holds until interrupt, then vectors
// - slow mode divides cpu and peripheral clock
// - mask restored from stacked condition code
// - service at instruction end, then fetch vector
// - stabilisation delay after halt wake, reset
// - two-bit polarity code per pair of external vectors (groups 0/1 share one, groups 2/3 the other)
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module icw_ctrl
    import icw_pkg::*;
#(
    parameter int STAB_CYCLES = ICW_STAB_CYCLES
) (
    input  wire logic                 i_core_clk,        // cpu clock
    input  wire logic                 i_rst_b,           // async reset, low
    // axi4-lite slave
    input  wire logic [7:0]           s_axi_awaddr,      // write address
    input  wire logic                 s_axi_awvalid,     // write address valid
    output logic                      s_axi_awready,     // write address ready
    input  wire logic [31:0]          s_axi_wdata,       // write data
    input  wire logic [3:0]           s_axi_wstrb,       // byte strobes
    input  wire logic                 s_axi_wvalid,      // write data valid
    output logic                      s_axi_wready,      // write data ready
    output logic [1:0]                s_axi_bresp,       // write response
    output logic                      s_axi_bvalid,      // response valid
    input  wire logic                 s_axi_bready,      // response ready
    input  wire logic [7:0]           s_axi_araddr,      // read address
    input  wire logic                 s_axi_arvalid,     // read address valid
    output logic                      s_axi_arready,     // read address ready
    output logic [31:0]               s_axi_rdata,       // read data
    output logic [1:0]                s_axi_rresp,       // read response
    output logic                      s_axi_rvalid,      // read data valid
    input  wire logic                 s_axi_rready,      // read data ready
    // external interrupt pins
    input  wire logic [ICW_NPIN-1:0]  i_ext_pin,         // raw pin levels
    // peripheral flags and clear-sequence pulses
    input  wire logic [ICW_NFLAG-1:0] i_periph_flag,     // status flag levels
    input  wire logic [ICW_NFLAG-1:0] i_periph_clr_seq,  // clear sequence done
    // core side
    input  wire logic                 i_instr_end,       // instruction boundary
    input  wire logic                 i_irq_taken,       // context pushed, entering
    input  wire logic                 i_trap,            // trap executed
    input  wire logic                 i_wfi,             // wait instruction
    input  wire logic                 i_halt,            // halt instruction
    input  wire logic                 i_mask_load,       // load mask from core
    input  wire logic                 i_mask_val,        // value for load
    output logic                      o_irq_valid,       // vector offered
    output logic [15:0]               o_vector_addr,     // selected vector
    output logic                      o_mask_bit,        // global mask
    output logic                      o_cpu_run,         // cpu clock enable
    output logic                      o_periph_run,      // peripheral clock enable
    output logic                      o_slow_en,         // slow mode
    output logic [1:0]                o_slow_prescale,   // slow divider select
    output logic                      o_clk_out_en       // clock to pin enable
);

    localparam logic [15:0] STAB_LAST = 16'(STAB_CYCLES - 1);

    typedef struct packed {
        icw_mode_e             mode;
        logic [15:0]           stab_cnt;
        logic                  boot_pend;
        logic                  trap_pend;
        logic                  mask;
        logic                  sel_valid;
        logic [15:0]           sel_addr;
        logic [ICW_NPIN-1:0]   pin_s1;
        logic [ICW_NPIN-1:0]   pin_s2;
        logic [3:0]            comb_prev;
        logic [3:0]            ext_edge;
        logic [ICW_NFLAG-1:0]  per_pend;
        logic [7:0]            misc;
        logic [ICW_NFLAG-1:0]  per_en;
        logic [ICW_NPIN-1:0]   pin_en;
        logic                  aw_hold;
        logic [7:0]            awaddr;
        logic                  w_hold;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } icw_state_s;

    icw_state_s st;
    icw_state_s next_st;

    // and of enabled pins; unenabled pins read as high
    function automatic logic grp_and(input logic [3:0] pins, input logic [3:0] en);
        grp_and = &(pins | ~en);
    endfunction

    // lowest index wins
    function automatic logic [15:0] pick_vec(input logic [ICW_NSRC-1:0] req);
        logic [15:0] v;
        v = ICW_VEC_RESET;
        for (int k = ICW_NSRC - 1; k >= 0; k--) begin
            if (req[k]) begin
                case (k)
                    0:       v = ICW_VEC_RESET;
                    1:       v = ICW_VEC_TRAP;
                    2:       v = ICW_VEC_EXT0;
                    3:       v = ICW_VEC_EXT1;
                    4:       v = ICW_VEC_EXT2;
                    5:       v = ICW_VEC_EXT3;
                    6:       v = ICW_VEC_SYNC;
                    7:       v = ICW_VEC_TMRA;
                    8:       v = ICW_VEC_TMRB;
                    9:       v = ICW_VEC_ASYN;
                    default: v = ICW_VEC_NVM;
                endcase
            end
        end
        pick_vec = v;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    logic [3:0]            grp_pins [4];
    logic [3:0]            grp_en   [4];
    logic [1:0]            grp_pol  [4];
    logic [3:0]            comb_now;
    logic [3:0]            level_req;
    logic [3:0]            edge_set;
    logic [3:0]            ext_req;
    logic [4:0]            per_req;
    logic [ICW_NFLAG-1:0]  per_act;
    logic [ICW_NSRC-1:0]   cand;
    logic                  mask_req;
    logic                  do_write;
    logic [31:0]           wr_old;
    logic [31:0]           wr_new;
    logic [3:0]            pol_clr;
    logic [3:0]            ack_clr;
    logic [ICW_NFLAG-1:0]  sw_clr;
    logic                  sel_now;

    always_comb begin
        grp_pins[0] = st.pin_s2[ICW_G0_LSB +: 4];
        grp_pins[1] = {1'b1, st.pin_s2[ICW_G1_LSB +: 3]};
        grp_pins[2] = st.pin_s2[ICW_G2_LSB +: 4];
        grp_pins[3] = st.pin_s2[ICW_G3_LSB +: 4];
        grp_en[0]   = st.pin_en[ICW_G0_LSB +: 4];
        grp_en[1]   = {1'b0, st.pin_en[ICW_G1_LSB +: 3]};
        grp_en[2]   = st.pin_en[ICW_G2_LSB +: 4];
        grp_en[3]   = st.pin_en[ICW_G3_LSB +: 4];
        grp_pol[0]  = st.misc[ICW_MISC_POL01 +: 2];
        grp_pol[1]  = st.misc[ICW_MISC_POL01 +: 2];
        grp_pol[2]  = st.misc[ICW_MISC_POL23 +: 2];
        grp_pol[3]  = st.misc[ICW_MISC_POL23 +: 2];
        for (int g = 0; g < 4; g++) begin
            comb_now[g] = grp_and(grp_pins[g], grp_en[g]);
            level_req[g] = 1'b0;
            edge_set[g] = 1'b0;
            if (|grp_en[g]) begin
                case (grp_pol[g])
                    ICW_POL_FALL_LOW: begin
                        edge_set[g]  = st.comb_prev[g] & ~comb_now[g];
                        level_req[g] = ~comb_now[g];
                    end
                    ICW_POL_FALL: edge_set[g] = st.comb_prev[g] & ~comb_now[g];
                    ICW_POL_RISE: edge_set[g] = ~st.comb_prev[g] & comb_now[g];
                    ICW_POL_BOTH: edge_set[g] = st.comb_prev[g] ^ comb_now[g];
                    default:      edge_set[g] = 1'b0;
                endcase
            end
            ext_req[g] = st.ext_edge[g] | level_req[g];
        end

        per_act = st.per_pend & st.per_en;
        per_req[0] = |per_act[ICW_SYNC_LSB +: ICW_SYNC_W];
        per_req[1] = |per_act[ICW_TMRA_LSB +: ICW_TMR_W];
        per_req[2] = |per_act[ICW_TMRB_LSB +: ICW_TMR_W];
        per_req[3] = |per_act[ICW_ASYN_LSB +: ICW_ASYN_W];
        per_req[4] = per_act[ICW_NVM_BIT];

        mask_req = ~st.mask & (|ext_req | |per_req);
        cand = {per_req & {5{~st.mask}}, ext_req & {4{~st.mask}}, st.trap_pend, st.boot_pend};

        do_write = st.aw_hold & st.w_hold & ~st.bvalid;
        case (st.awaddr)
            ICW_OFF_MISC:       wr_old = {24'h000000, st.misc};
            ICW_OFF_PERIPH_EN:  wr_old = {14'h0000, st.per_en};
            ICW_OFF_PERIPH_PND: wr_old = {14'h0000, st.per_pend};
            ICW_OFF_PIN_EN:     wr_old = {17'h00000, st.pin_en};
            default:            wr_old = 32'h00000000;
        endcase
        wr_new = merge(wr_old, st.wdata, st.wstrb);

        pol_clr = 4'h0;
        sw_clr = '0;
        if (do_write && st.awaddr == ICW_OFF_MISC) begin
            pol_clr[1:0] = {2{wr_new[ICW_MISC_POL01 +: 2] != st.misc[ICW_MISC_POL01 +: 2]}};
            pol_clr[3:2] = {2{wr_new[ICW_MISC_POL23 +: 2] != st.misc[ICW_MISC_POL23 +: 2]}};
        end
        if (do_write && st.awaddr == ICW_OFF_PERIPH_PND) begin
            sw_clr = ~wr_new[ICW_NFLAG-1:0];
        end

        ack_clr = 4'h0;
        if (i_irq_taken && st.sel_valid) begin
            ack_clr[0] = st.sel_addr == ICW_VEC_EXT0;
            ack_clr[1] = st.sel_addr == ICW_VEC_EXT1;
            ack_clr[2] = st.sel_addr == ICW_VEC_EXT2;
            ack_clr[3] = st.sel_addr == ICW_VEC_EXT3;
        end

        next_st = st;
        next_st.pin_s1 = i_ext_pin;
        next_st.pin_s2 = st.pin_s1;
        next_st.comb_prev = comb_now;
        // set wins over every clear
        next_st.ext_edge = (st.ext_edge & ~ack_clr & ~pol_clr) | edge_set;
        next_st.per_pend = (st.per_pend & ~i_periph_clr_seq & ~sw_clr) | i_periph_flag;

        if (i_mask_load) begin
            next_st.mask = i_mask_val;
        end
        if (i_trap) begin
            next_st.trap_pend = 1'b1;
        end

        sel_now = 1'b0;
        case (st.mode)
            ICW_RUN: begin
                if (i_wfi) begin
                    next_st.mode = ICW_WAIT;
                    next_st.mask = 1'b0;
                end else if (i_halt) begin
                    next_st.mode = ICW_HALT;
                    next_st.mask = 1'b0;
                end else if (i_instr_end && !st.sel_valid) begin
                    sel_now = 1'b1;
                end
            end
            ICW_WAIT: begin
                if (mask_req) begin
                    next_st.mode = ICW_RUN;
                    sel_now = 1'b1;
                end
            end
            ICW_HALT: begin
                if (|ext_req) begin
                    next_st.mode = ICW_STAB;
                    next_st.stab_cnt = 16'h0000;
                end
            end
            ICW_STAB: begin
                if (st.stab_cnt == STAB_LAST) begin
                    next_st.mode = ICW_RUN;
                    sel_now = 1'b1;
                end else begin
                    next_st.stab_cnt = st.stab_cnt + 16'h0001;
                end
            end
            default: next_st.mode = ICW_RUN;
        endcase

        if (i_irq_taken && st.sel_valid) begin
            next_st.sel_valid = 1'b0;
            next_st.mask = 1'b1;
            if (st.sel_addr == ICW_VEC_TRAP) begin
                next_st.trap_pend = i_trap;
            end
            if (st.sel_addr == ICW_VEC_RESET) begin
                next_st.boot_pend = 1'b0;
            end
        end else if (sel_now && !st.sel_valid && |cand) begin
            next_st.sel_valid = 1'b1;
            next_st.sel_addr = pick_vec(cand);
        end

        // axi write path
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_hold = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_hold = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (do_write) begin
            next_st.aw_hold = 1'b0;
            next_st.w_hold = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = ICW_RESP_OKAY;
            case (st.awaddr)
                ICW_OFF_MISC:       next_st.misc = wr_new[7:0];
                ICW_OFF_PERIPH_EN:  next_st.per_en = wr_new[ICW_NFLAG-1:0];
                ICW_OFF_PERIPH_PND: next_st.bresp = ICW_RESP_OKAY;
                ICW_OFF_PIN_EN:     next_st.pin_en = wr_new[ICW_NPIN-1:0];
                ICW_OFF_STATUS:     next_st.bresp = ICW_RESP_OKAY;
                default:            next_st.bresp = ICW_RESP_SLVERR;
            endcase
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // axi read path
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = ICW_RESP_OKAY;
            case (s_axi_araddr)
                ICW_OFF_MISC:       next_st.rdata = {24'h000000, st.misc};
                ICW_OFF_PERIPH_EN:  next_st.rdata = {14'h0000, st.per_en};
                ICW_OFF_PERIPH_PND: next_st.rdata = {14'h0000, st.per_pend};
                ICW_OFF_PIN_EN:     next_st.rdata = {17'h00000, st.pin_en};
                ICW_OFF_STATUS: begin
                    next_st.rdata = {10'h000, st.boot_pend, st.trap_pend, st.ext_edge, st.sel_addr[7:0],
                                     4'h0, st.sel_valid, st.mask, st.mode};
                end
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = ICW_RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st <= '0;
            st.mode <= ICW_STAB;
            st.boot_pend <= 1'b1;
            st.mask <= 1'b1;
            st.pin_s1 <= '1;
            st.pin_s2 <= '1;
            st.comb_prev <= 4'hf;
            st.misc <= ICW_RST_MISC;
            st.per_en <= ICW_RST_PERIPH_EN;
            st.pin_en <= ICW_RST_PIN_EN;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready   = ~st.aw_hold & ~st.bvalid;
    assign s_axi_wready    = ~st.w_hold & ~st.bvalid;
    assign s_axi_bvalid    = st.bvalid;
    assign s_axi_bresp     = st.bresp;
    assign s_axi_arready   = ~st.rvalid;
    assign s_axi_rvalid    = st.rvalid;
    assign s_axi_rdata     = st.rdata;
    assign s_axi_rresp     = st.rresp;
    assign o_irq_valid     = st.sel_valid;
    assign o_vector_addr   = st.sel_addr;
    assign o_mask_bit      = st.mask;
    assign o_cpu_run       = st.mode == ICW_RUN;
    assign o_periph_run    = st.mode != ICW_HALT;
    assign o_slow_en       = st.misc[ICW_MISC_SLOW];
    assign o_slow_prescale = st.misc[ICW_MISC_PSC_LSB +: 2];
    assign o_clk_out_en    = st.misc[ICW_MISC_CLKOUT];

endmodule
`default_nettype wire

// ===== hw/icw_pkg.sv
// package for the interrupt priority and wait/wake controller
package icw_pkg;

    // register byte offsets
    localparam logic [7:0] ICW_OFF_MISC       = 8'h00;
    localparam logic [7:0] ICW_OFF_PERIPH_EN  = 8'h04;
    localparam logic [7:0] ICW_OFF_PERIPH_PND = 8'h08;
    localparam logic [7:0] ICW_OFF_PIN_EN     = 8'h0c;
    localparam logic [7:0] ICW_OFF_STATUS     = 8'h10;

    // reset values
    localparam logic [7:0]  ICW_RST_MISC      = 8'h00;
    localparam logic [17:0] ICW_RST_PERIPH_EN = 18'h00000;
    localparam logic [14:0] ICW_RST_PIN_EN    = 15'h0000;

    // miscellaneous register fields
    localparam int ICW_MISC_SLOW    = 0;
    localparam int ICW_MISC_PSC_LSB = 1;
    localparam int ICW_MISC_POL01   = 3;
    localparam int ICW_MISC_CLKOUT  = 5;
    localparam int ICW_MISC_POL23   = 6;

    // peripheral flag layout: sync serial, timer a, timer b, async serial, nvm
    localparam int ICW_NFLAG = 18;
    localparam int ICW_SYNC_LSB = 0;
    localparam int ICW_SYNC_W   = 2;
    localparam int ICW_TMRA_LSB = 2;
    localparam int ICW_TMRB_LSB = 7;
    localparam int ICW_TMR_W    = 5;
    localparam int ICW_ASYN_LSB = 12;
    localparam int ICW_ASYN_W   = 5;
    localparam int ICW_NVM_BIT  = 17;

    // external pin layout: group0 pa0-3, group1 pf0-2, group2 pb0-3, group3 pb4-7
    localparam int ICW_NPIN = 15;
    localparam int ICW_G0_LSB = 0;
    localparam int ICW_G1_LSB = 4;
    localparam int ICW_G2_LSB = 7;
    localparam int ICW_G3_LSB = 11;

    // polarity codes
    localparam logic [1:0] ICW_POL_FALL_LOW = 2'b00;
    localparam logic [1:0] ICW_POL_FALL     = 2'b10;
    localparam logic [1:0] ICW_POL_RISE     = 2'b01;
    localparam logic [1:0] ICW_POL_BOTH     = 2'b11;

    // vectors, highest priority first
    localparam int ICW_NSRC = 11;
    localparam logic [15:0] ICW_VEC_RESET = 16'hfffe;
    localparam logic [15:0] ICW_VEC_TRAP  = 16'hfffc;
    localparam logic [15:0] ICW_VEC_EXT0  = 16'hfff6;
    localparam logic [15:0] ICW_VEC_EXT1  = 16'hfff4;
    localparam logic [15:0] ICW_VEC_EXT2  = 16'hfff2;
    localparam logic [15:0] ICW_VEC_EXT3  = 16'hfff0;
    localparam logic [15:0] ICW_VEC_SYNC  = 16'hffec;
    localparam logic [15:0] ICW_VEC_TMRA  = 16'hffea;
    localparam logic [15:0] ICW_VEC_TMRB  = 16'hffe8;
    localparam logic [15:0] ICW_VEC_ASYN  = 16'hffe6;
    localparam logic [15:0] ICW_VEC_NVM   = 16'hffe4;

    // oscillator stabilisation after reset or halt wake
    localparam int ICW_STAB_CYCLES = 4096;

    localparam logic [1:0] ICW_RESP_OKAY   = 2'b00;
    localparam logic [1:0] ICW_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ICW_RUN  = 2'b00,
        ICW_WAIT = 2'b01,
        ICW_HALT = 2'b10,
        ICW_STAB = 2'b11
    } icw_mode_e;

endpackage

// ===== sim/icw_checker.sv
// port assertions for the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module icw_checker #(
    parameter int STAB_CYCLES = 4096
) (
    input wire logic        i_core_clk,    // clock
    input wire logic        i_rst_b,       // reset
    input wire logic        i_wfi,         // wait
    input wire logic        i_irq_taken,   // entry
    input wire logic        o_irq_valid,   // offer
    input wire logic [15:0] o_vector_addr, // vector
    input wire logic        o_mask_bit,    // mask
    input wire logic        o_cpu_run,     // cpu on
    input wire logic        o_periph_run   // periph on
);
    default clocking dc @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    vec_legal_a: assert property (o_irq_valid |-> o_vector_addr[15:5] == 11'h7ff)
        else $error("vector out of table");
    mask_set_a: assert property (o_irq_valid && i_irq_taken |=> o_mask_bit && !o_irq_valid)
        else $error("entry left mask clear");
    offer_hold_a: assert property (o_irq_valid && !i_irq_taken |=> o_irq_valid && $stable(o_vector_addr))
        else $error("offer changed early");
    mask_gate_a: assert property ($rose(o_irq_valid) && o_vector_addr < 16'hfffc |-> !$past(o_mask_bit))
        else $error("offer under mask");
    wait_entry_a: assert property (i_wfi && o_cpu_run && !o_irq_valid |=> !o_cpu_run && o_periph_run && !o_mask_bit)
        else $error("wait entry wrong");
    halt_quiet_a: assert property (!o_periph_run |-> !o_irq_valid && !o_cpu_run)
        else $error("activity in halt");
    stab_hold_a: assert property ($rose(o_periph_run) |-> !o_cpu_run [*4])
        else $error("cpu ran too soon");
    wake_vec_a: assert property ($rose(o_cpu_run) |-> o_irq_valid)
        else $error("wake without vector");
endmodule
`default_nettype wire

// ===== sim/icw_core_model.sv
// core stand-in: instruction boundaries and vector entry
`timescale 1ns/1ps
`default_nettype none
module icw_core_model (
    input  wire logic i_core_clk,  // clock
    input  wire logic i_rst_b,     // reset
    input  wire logic i_irq_valid, // vector offered
    input  wire logic i_cpu_run,   // cpu clocked
    output logic      o_instr_end, // boundary pulse
    output logic      o_irq_taken  // entry pulse
);
    logic [2:0] cnt;
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 3'h0;
            o_instr_end <= 1'b0;
            o_irq_taken <= 1'b0;
        end else begin
            cnt <= i_cpu_run ? cnt + 3'h1 : 3'h0;
            o_instr_end <= i_cpu_run && cnt == 3'h3;
            // context push takes a while before entry
            o_irq_taken <= i_irq_valid && cnt == 3'h6;
        end
    end
endmodule
`default_nettype wire

// ===== sim/interrupt_priority_and_wait_wake_test.sv
// testbench: vector priority, masking, wait and halt wake
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_and_wait_wake_test import icw_pkg::*;;
    logic        clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic        awr, wr, bv, arr, rv, valid, mask, run, prun, slow, ie, tk, cko;
    logic        trap = 0, wait_for_interrupt_instruction = 0, halt = 0, mld = 0;
    logic [1:0]  bresp, rresp, psc;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rd;
    logic [14:0] pin = '1;
    logic [17:0] flag = 0, clr = 0;
    logic [15:0] vec;
    logic [15:0] vt [9] = '{16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0,
                            16'hffec, 16'hffea, 16'hffe8, 16'hffe6, 16'hffe4};
    int          bt [5] = '{0, 2, 7, 12, 17};
    int          errors = 0, n_checks = 0;
    always #5 clk = ~clk;
    icw_ctrl #(.STAB_CYCLES(8)) dut (.i_core_clk(clk), .i_rst_b(rst_b),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rry), .i_ext_pin(pin), .i_periph_flag(flag), .i_periph_clr_seq(clr),
        .i_instr_end(ie), .i_irq_taken(tk), .i_trap(trap), .i_wfi(wait_for_interrupt_instruction), .i_halt(halt),
        .i_mask_load(mld), .i_mask_val(1'b0), .o_irq_valid(valid), .o_vector_addr(vec),
        .o_mask_bit(mask), .o_cpu_run(run), .o_periph_run(prun), .o_slow_en(slow),
        .o_slow_prescale(psc), .o_clk_out_en(cko));
    icw_core_model core (.i_core_clk(clk), .i_rst_b(rst_b), .i_irq_valid(valid),
        .i_cpu_run(run), .o_instr_end(ie), .o_irq_taken(tk));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        bry <= 1;
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 0;
            if (wv && wr) wv <= 0;
        end while (awv && !awr || wv && !wr);
        do @(posedge clk);
        while (!bv);
        bry <= 0;
        chk(32'(bresp), 32'(a > ICW_OFF_STATUS ? ICW_RESP_SLVERR : ICW_RESP_OKAY));
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] e);
        ara <= a;
        arv <= 1;
        rry <= 1;
        do @(posedge clk);
        while (!arr);
        arv <= 0;
        do @(posedge clk);
        while (!rv);
        rry <= 0;
        chk(rd, e);
        chk(32'(rresp), 32'(a > ICW_OFF_STATUS ? ICW_RESP_SLVERR : ICW_RESP_OKAY));
    endtask
    task automatic svc(input logic [15:0] v);
        while (!valid) @(posedge clk);
        chk(32'(vec), 32'(v));
        while (valid) @(posedge clk);
        chk(32'(mask), 1);
    endtask
    task automatic mclr;
        @(posedge clk) mld <= 1;
        @(posedge clk) mld <= 0;
    endtask
    task automatic quiet;
        logic s;
        s = 0;
        repeat (20) begin
            @(posedge clk);
            s |= valid;
        end
        chk(32'(s), 0);
    endtask
    task automatic end_sim;
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1;
        svc(16'hfffe);
        axw(ICW_OFF_PERIPH_EN, 32'h3ffff);
        flag <= 18'h21085;
        quiet;
        axr(ICW_OFF_PERIPH_PND, 32'h21085);
        for (int i = 4; i < 9; i++) begin
            mclr;
            svc(vt[i]);
            flag[bt[i-4]] <= 0;
            axw(ICW_OFF_PERIPH_PND, ~(32'h1 << bt[i-4]));
        end
        axr(ICW_OFF_PERIPH_PND, 0);
        @(posedge clk) flag <= 18'h4;
        @(posedge clk) flag <= 0;
        clr <= 18'h4;
        @(posedge clk) clr <= 0;
        mclr;
        quiet;
        axw(ICW_OFF_PIN_EN, 32'h7fff);
        pin <= 0;
        repeat (6) @(posedge clk);
        pin <= '1;
        for (int i = 0; i < 4; i++) begin
            if (i > 0) mclr;
            svc(vt[i]);
        end
        mclr;
        quiet;
        axw(ICW_OFF_MISC, 32'h2f);
        chk(32'({slow, psc, cko}), 32'hf);
        @(posedge clk) pin[0] <= 0;
        @(posedge clk) pin[1] <= 0;
        @(posedge clk) pin[1] <= 1;
        quiet;
        pin[0] <= 1;
        svc(16'hfff6);
        @(posedge clk) trap <= 1;
        @(posedge clk) trap <= 0;
        svc(16'hfffc);
        @(posedge clk) wait_for_interrupt_instruction <= 1;
        @(posedge clk) wait_for_interrupt_instruction <= 0;
        @(posedge clk);
        chk(32'({run, prun, mask}), 32'h2);
        flag <= 18'h4;
        svc(16'hffea);
        flag <= 0;
        axw(ICW_OFF_PERIPH_PND, 0);
        @(posedge clk) halt <= 1;
        @(posedge clk) halt <= 0;
        flag <= 18'h4;
        quiet;
        chk(32'({prun, mask}), 0);
        flag <= 0;
        pin[11] <= 0;
        svc(16'hfff0);
        pin[11] <= 1;
        mclr;
        svc(16'hffea);
        axr(8'h14, 0);
        end_sim;
    end
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_sim;
    end
endmodule
bind icw_ctrl icw_checker #(.STAB_CYCLES(STAB_CYCLES)) u_check (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
    .i_wfi(i_wfi), .i_irq_taken(i_irq_taken), .o_irq_valid(o_irq_valid), .o_vector_addr(o_vector_addr),
    .o_mask_bit(o_mask_bit), .o_cpu_run(o_cpu_run), .o_periph_run(o_periph_run));
`default_nettype wire
